/* inc/fech_defines.svh */
// Constants for the enclosure command handler
`ifndef FECH_DEFINES_SVH
`define FECH_DEFINES_SVH

// ----------------------------------------
// Command unit layout
// ----------------------------------------
`define FECH_CMD_LAST    8'd31
`define FECH_LUN_FIRST   0
`define FECH_CNTL_FIRST  8
`define FECH_CDB_FIRST   12
`define FECH_DL_FIRST    28

// ----------------------------------------
// Control values and opcodes
// ----------------------------------------
`define FECH_CNTL_WRITE  32'h0000_0001
`define FECH_CNTL_READ   32'h0000_0002
`define FECH_OP_INQUIRY  8'h12
`define FECH_OP_RPT_LUN  8'ha0
`define FECH_OP_REQ_SNS  8'h03
`define FECH_OP_TUR      8'h00

// ----------------------------------------
// Response layout and status
// ----------------------------------------
`define FECH_RSP_HDR     8'h18
`define FECH_SNS_LEN     8'h12
`define FECH_INQ_LEN     8'h24
`define FECH_RLUN_LEN    8'h10
`define FECH_ST_GOOD     8'h00
`define FECH_ST_CHECK    8'h02
`define FECH_KEY_NONE    4'h0
`define FECH_KEY_NRDY    4'h2
`define FECH_KEY_ILLEGAL 4'h5
`define FECH_ASC_NONE    8'h00
`define FECH_ASC_NRDY    8'h04
`define FECH_ASC_BAD_OP  8'h20
`define FECH_ASC_BAD_FLD 8'h24
`define FECH_ASC_BAD_LUN 8'h25
`define FECH_PDT_ENCL    8'h0d
`define FECH_ENCSERV     8'h40

`endif

/* inc/fech_pkg.sv */
// Types for the enclosure command handler
package fech_pkg;

    typedef enum logic [2:0] {
        ST_CMD,
        ST_EVAL,
        ST_XRDY,
        ST_DATA,
        ST_RSP
    } fech_state_t;

endpackage

/* rtl/fech_cmd_handler.sv */
// Command unit parser, transfer sequencer and response builder
//
// Notes on behaviour
// - All-zero 8-byte LUN field addresses the local switch.
// - Control field 1 means write, 2 means read; others are invalid.
// - Bytes 12 to 27 carry the 16-byte command descriptor block.
// - Bytes 28 to 31 cap the data moved; never move more.
// - Transfer-ready is sent only once the data transfer can proceed.
// - A transfer-ready unit precedes every data unit.
// - Response: 8 reserved, status, residual, sense len, info len, data.
// - Status byte 2 bit1 sense valid, bit0 info valid; byte 3 SCSI code.
// - Underrun sets byte 2 bit 3, residual is bytes not moved.
// - Overrun sets byte 2 bit 2, residual is bytes dropped.
// - All reserved status bits read as zero.
// - Opcode 12h is inquiry, returning enclosure device information.
// - Opcode A0h is report LUN, listing attached logical units.
// - Opcode 03h is request sense, returning sense information.
// - Opcode 00h is test unit ready, reporting unit state.
// - The basic command set needs no feature unlock key.
// - Standard inquiry with nonzero page code gives check condition.
`timescale 1ns/100ps
`include "fech_defines.svh"

module fech_cmd_handler
    import fech_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [7:0]  cmd_data,
    input  wire logic        unit_ready,
    output logic             xrdy_valid,
    input  wire logic        xrdy_ready,
    output logic [31:0]      xrdy_len,
    output logic             dout_valid,
    input  wire logic        dout_ready,
    output logic [7:0]       dout_data,
    output logic             dout_last,
    output logic             rsp_valid,
    input  wire logic        rsp_ready,
    output logic [7:0]       rsp_data,
    output logic             rsp_last
);

    default clocking dflt_cb @(posedge clock); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // State
    // ----------------------------------------
    fech_state_t state_q, state_d;
    logic [7:0]  cmd_q [0:31];
    logic [7:0]  cmd_d [0:31];
    logic [7:0]  cnt_q, cnt_d;
    logic [7:0]  len_q, len_d;
    logic [7:0]  obyte_q, obyte_d;
    logic [7:0]  scsi_q, scsi_d;
    logic        under_q, under_d;
    logic        over_q, over_d;
    logic        sns_q, sns_d;
    logic [31:0] resid_q, resid_d;
    logic [3:0]  key_q, key_d;
    logic [7:0]  asc_q, asc_d;
    logic [7:0]  op_q, op_d;

    // ----------------------------------------
    // Field views of the held command
    // ----------------------------------------
    logic        lun_zero;
    logic [31:0] cntl;
    logic [31:0] dl;
    logic [7:0]  op;
    logic [7:0]  page;
    logic        evpd;
    logic        cmddt;
    logic        cntl_ok;
    logic [7:0]  rsp_n;

    assign lun_zero = {cmd_q[0], cmd_q[1], cmd_q[2], cmd_q[3],
                       cmd_q[4], cmd_q[5], cmd_q[6], cmd_q[7]}
                      == 64'h0;
    assign cntl = {cmd_q[`FECH_CNTL_FIRST], cmd_q[`FECH_CNTL_FIRST+1],
                   cmd_q[`FECH_CNTL_FIRST+2], cmd_q[`FECH_CNTL_FIRST+3]};
    assign dl = {cmd_q[`FECH_DL_FIRST], cmd_q[`FECH_DL_FIRST+1],
                 cmd_q[`FECH_DL_FIRST+2], cmd_q[`FECH_DL_FIRST+3]};
    assign op = cmd_q[`FECH_CDB_FIRST];
    assign evpd = cmd_q[`FECH_CDB_FIRST+1][0];
    assign cmddt = cmd_q[`FECH_CDB_FIRST+1][1];
    assign page = cmd_q[`FECH_CDB_FIRST+2];
    assign cntl_ok = (cntl == `FECH_CNTL_WRITE)
                  || (cntl == `FECH_CNTL_READ);
    assign rsp_n = sns_q ? (`FECH_RSP_HDR + `FECH_SNS_LEN)
                         : `FECH_RSP_HDR;

    // ----------------------------------------
    // Byte builders
    // ----------------------------------------
    function automatic logic [7:0] sense_byte(input logic [7:0] i,
                                              input logic [3:0] key,
                                              input logic [7:0] asc);
        case (i)
            8'h00:   sense_byte = 8'h70;
            8'h02:   sense_byte = {4'h0, key};
            8'h07:   sense_byte = 8'h0a;
            8'h0c:   sense_byte = asc;
            default: sense_byte = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] data_byte(input logic [7:0] i);
        data_byte = 8'h00;
        case (op_q)
            `FECH_OP_INQUIRY: begin
                if (i == 8'h00) data_byte = `FECH_PDT_ENCL;
                if (i == 8'h04) data_byte = `FECH_INQ_LEN - 8'h05;
                if (i == 8'h06) data_byte = `FECH_ENCSERV;
            end
            // Only the local unit is listed: one 8-byte entry of zero
            `FECH_OP_RPT_LUN: begin
                if (i == 8'h03) data_byte = 8'h08;
            end
            `FECH_OP_REQ_SNS: begin
                data_byte = sense_byte(i, key_q, asc_q);
            end
            default: data_byte = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] rsp_byte(input logic [7:0] i);
        rsp_byte = 8'h00;
        case (i)
            8'h0a: rsp_byte = {4'h0, under_q, over_q,
                               sns_q, 1'b0};
            8'h0b: rsp_byte = scsi_q;
            8'h0c: rsp_byte = resid_q[31:24];
            8'h0d: rsp_byte = resid_q[23:16];
            8'h0e: rsp_byte = resid_q[15:8];
            8'h0f: rsp_byte = resid_q[7:0];
            8'h13: rsp_byte = sns_q ? `FECH_SNS_LEN : 8'h00;
            default: begin
                if (i >= `FECH_RSP_HDR) begin
                    rsp_byte = sense_byte(i - `FECH_RSP_HDR,
                                          key_q, asc_q);
                end
            end
        endcase
    endfunction

    // ----------------------------------------
    // Decode of a complete command
    // ----------------------------------------
    logic        ev_chk;
    logic [3:0]  ev_key;
    logic [7:0]  ev_asc;
    logic [31:0] ev_nat;

    // No unlock key input: the basic set is always served
    always_comb begin
        ev_chk = 1'b1;
        ev_key = `FECH_KEY_ILLEGAL;
        ev_asc = `FECH_ASC_NONE;
        ev_nat = 32'h0;
        if (!lun_zero) begin
            ev_asc = `FECH_ASC_BAD_LUN;
        end else if (!cntl_ok) begin
            ev_asc = `FECH_ASC_BAD_FLD;
        end else begin
            case (op)
                `FECH_OP_INQUIRY: begin
                    if (!evpd && !cmddt && page != 8'h00) begin
                        ev_asc = `FECH_ASC_BAD_FLD;
                    end else begin
                        ev_chk = 1'b0;
                        ev_nat = {24'h0, `FECH_INQ_LEN};
                    end
                end
                `FECH_OP_RPT_LUN: begin
                    ev_chk = 1'b0;
                    ev_nat = {24'h0, `FECH_RLUN_LEN};
                end
                `FECH_OP_REQ_SNS: begin
                    ev_chk = 1'b0;
                    ev_nat = {24'h0, `FECH_SNS_LEN};
                end
                `FECH_OP_TUR: begin
                    ev_chk = !unit_ready;
                    ev_key = `FECH_KEY_NRDY;
                    ev_asc = `FECH_ASC_NRDY;
                end
                default: ev_asc = `FECH_ASC_BAD_OP;
            endcase
        end
        // A write carries nothing for these commands
        if (cntl == `FECH_CNTL_WRITE) ev_nat = 32'h0;
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        cmd_d = cmd_q;
        cnt_d = cnt_q;
        len_d = len_q;
        scsi_d = scsi_q;
        under_d = under_q;
        over_d = over_q;
        sns_d = sns_q;
        resid_d = resid_q;
        key_d = key_q;
        asc_d = asc_q;
        op_d = op_q;
        case (state_q)
            ST_CMD: begin
                if (cmd_valid) begin
                    cmd_d[cnt_q[4:0]] = cmd_data;
                    cnt_d = cnt_q + 8'h01;
                    if (cnt_q == `FECH_CMD_LAST) begin
                        cnt_d = 8'h00;
                        state_d = ST_EVAL;
                    end
                end
            end
            ST_EVAL: begin
                op_d = op;
                under_d = 1'b0;
                over_d = 1'b0;
                resid_d = 32'h0;
                len_d = 8'h00;
                sns_d = ev_chk;
                scsi_d = ev_chk ? `FECH_ST_CHECK : `FECH_ST_GOOD;
                if (ev_chk) begin
                    key_d = ev_key;
                    asc_d = ev_asc;
                end else if (dl > ev_nat) begin
                    under_d = 1'b1;
                    resid_d = dl - ev_nat;
                    len_d = ev_nat[7:0];
                end else begin
                    over_d = ev_nat > dl;
                    resid_d = ev_nat - dl;
                    len_d = dl[7:0];
                end
                state_d = (!ev_chk && len_d != 8'h00) ? ST_XRDY : ST_RSP;
            end
            ST_XRDY: begin
                if (xrdy_ready) state_d = ST_DATA;
            end
            ST_DATA: begin
                if (dout_ready) begin
                    cnt_d = cnt_q + 8'h01;
                    if (dout_last) begin
                        cnt_d = 8'h00;
                        state_d = ST_RSP;
                    end
                end
            end
            ST_RSP: begin
                if (rsp_ready) begin
                    cnt_d = cnt_q + 8'h01;
                    if (rsp_last) begin
                        cnt_d = 8'h00;
                        state_d = ST_CMD;
                        // Sense is consumed once it has been reported
                        if (op_q == `FECH_OP_REQ_SNS || sns_q) begin
                            key_d = `FECH_KEY_NONE;
                            asc_d = `FECH_ASC_NONE;
                        end
                    end
                end
            end
            default: state_d = ST_CMD;
        endcase
        // Output byte is prepared one cycle ahead so data leaves a flop
        obyte_d = (state_d == ST_DATA) ? data_byte(cnt_d)
                                       : rsp_byte(cnt_d);
    end

    always_ff @(posedge clock) begin
        cmd_q <= cmd_d;
        if (rst) begin
            state_q <= ST_CMD;
            cnt_q <= 8'h00;
            len_q <= 8'h00;
            obyte_q <= 8'h00;
            scsi_q <= `FECH_ST_GOOD;
            under_q <= 1'b0;
            over_q <= 1'b0;
            sns_q <= 1'b0;
            resid_q <= 32'h0;
            key_q <= `FECH_KEY_NONE;
            asc_q <= `FECH_ASC_NONE;
            op_q <= `FECH_OP_TUR;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            len_q <= len_d;
            obyte_q <= obyte_d;
            scsi_q <= scsi_d;
            under_q <= under_d;
            over_q <= over_d;
            sns_q <= sns_d;
            resid_q <= resid_d;
            key_q <= key_d;
            asc_q <= asc_d;
            op_q <= op_d;
        end
    end

    // ----------------------------------------
    // Ports
    // ----------------------------------------
    assign cmd_ready = state_q == ST_CMD;
    assign xrdy_valid = state_q == ST_XRDY;
    assign xrdy_len = {24'h0, len_q};
    assign dout_valid = state_q == ST_DATA;
    assign dout_data = obyte_q;
    assign dout_last = dout_valid && (cnt_q == len_q - 8'h01);
    assign rsp_valid = state_q == ST_RSP;
    assign rsp_data = obyte_q;
    assign rsp_last = rsp_valid && (cnt_q == rsp_n - 8'h01);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_lun_local: assert property (state_q == ST_EVAL && !lun_zero
        |=> scsi_q == `FECH_ST_CHECK && asc_q == `FECH_ASC_BAD_LUN)
        else $error("remote LUN not rejected");
    a_cntl_value: assert property (state_q == ST_EVAL && lun_zero
        && !cntl_ok |=> scsi_q == `FECH_ST_CHECK && len_q == 8'h00)
        else $error("invalid control value accepted");
    a_inq_decode: assert property (state_q == ST_EVAL && lun_zero
        && cntl == `FECH_CNTL_READ && op == `FECH_OP_INQUIRY && evpd
        && dl >= 32'h24 |=> len_q == `FECH_INQ_LEN && !sns_q)
        else $error("inquiry length wrong");
    a_rlun_decode: assert property (state_q == ST_EVAL && lun_zero
        && cntl == `FECH_CNTL_READ && op == `FECH_OP_RPT_LUN
        && dl == 32'h10 |=> len_q == `FECH_RLUN_LEN && !under_q && !over_q)
        else $error("report LUN length wrong");
    a_xfer_bound: assert property (dout_valid && dout_ready
        |-> cnt_q < len_q && xrdy_len <= dl)
        else $error("data beyond allowed length");
    a_xrdy_first: assert property ($rose(dout_valid)
        |-> $past(state_q) == ST_XRDY && $past(xrdy_ready))
        else $error("data without transfer ready");
    a_status_bits: assert property (rsp_valid && cnt_q == 8'h0a
        |-> obyte_q[7:4] == 4'h0 && obyte_q[0] == 1'b0
        && obyte_q[1] == sns_q && obyte_q[3] == under_q)
        else $error("status byte 2 wrong");
    a_status_code: assert property (rsp_valid && cnt_q == 8'h0b
        ##0 (rsp_ready [*1]) |=> rsp_data == resid_q[31:24])
        else $error("residual does not follow status");
    // The flags stay from the last command until evaluate reloads them
    a_under_resid: assert property (under_q && state_q != ST_CMD
        && state_q != ST_EVAL
        |-> resid_q == dl - xrdy_len && !over_q)
        else $error("underrun residual wrong");
    a_over_resid: assert property (over_q && state_q != ST_CMD
        && state_q != ST_EVAL
        |-> resid_q != 32'h0 && xrdy_len == dl && !under_q)
        else $error("overrun residual wrong");
    a_tur_state: assert property (state_q == ST_EVAL && lun_zero
        && cntl_ok && op == `FECH_OP_TUR
        |=> (scsi_q == `FECH_ST_GOOD) == $past(unit_ready)
        ##1 rsp_valid)
        else $error("test unit ready status wrong");
    a_inq_page: assert property (state_q == ST_EVAL && lun_zero
        && cntl_ok && op == `FECH_OP_INQUIRY && !evpd && !cmddt
        && page != 8'h00 |=> scsi_q == `FECH_ST_CHECK ##1 rsp_valid)
        else $error("bad page code not rejected");
    a_one_resp: assert property (rsp_valid && rsp_ready && rsp_last
        |=> cmd_ready && !rsp_valid && cnt_q == 8'h00)
        else $error("response not closed once");

    c_inq_read: cover property (dout_valid && dout_ready && dout_last
        && op_q == `FECH_OP_INQUIRY);
    c_check_rsp: cover property (rsp_valid && rsp_last && sns_q);
    c_underrun: cover property (rsp_valid && rsp_last && under_q);
    c_overrun: cover property (rsp_valid && rsp_last && over_q);

endmodule // fech_cmd_handler

/* tb/fech_cmd_handler_tb.sv */
// Self-checking bench for the enclosure command handler
`timescale 1ns/100ps
`include "fech_defines.svh"

module fech_cmd_handler_tb
    import fech_pkg::*;
;
    typedef struct {
        logic [31:0] s10, s11, res, sl, nr, nd, nx, xl, d0, key, asc;
    } fech_exp_t;

    logic        clock, rst, unit_ready, slow;
    logic [2:0]  stall;
    logic        cmd_valid, cmd_ready, xrdy_valid, xrdy_ready;
    logic        dout_valid, dout_ready, rsp_valid, rsp_ready, rsp_last;
    logic        dout_last;
    logic [7:0]  cmd_data, dout_data, rsp_data, op;
    logic [31:0] xrdy_len, r;
    fech_exp_t   q [$];
    int          fails, tests_run, cyc, tnum, t;
    integer      seed;
    logic [7:0]  ops [0:3];

    fech_cmd_handler fech_cmd_handler_inst (
        .clock(clock), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_data(cmd_data),
        .unit_ready(unit_ready), .xrdy_valid(xrdy_valid),
        .xrdy_ready(xrdy_ready), .xrdy_len(xrdy_len),
        .dout_valid(dout_valid), .dout_ready(dout_ready),
        .dout_data(dout_data), .dout_last(dout_last), .rsp_valid(rsp_valid),
        .rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_last(rsp_last));

    fech_initiator_model fech_initiator_model_inst (
        .clock(clock), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_data(cmd_data),
        .xrdy_valid(xrdy_valid), .xrdy_ready(xrdy_ready),
        .xrdy_len(xrdy_len), .dout_valid(dout_valid),
        .dout_ready(dout_ready), .dout_data(dout_data),
        .dout_last(dout_last),
        .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
        .rsp_data(rsp_data), .rsp_last(rsp_last), .slow(slow),
        .stall(stall));

    always #2.5 clock = ~clock;

    always @(posedge clock) begin
        #1;
        stall = 3'($random(seed));
        cyc++;
        // Whole run needs about 2500 cycles
        if (cyc == 20000) begin
            fails++;
            stop_test();
        end
    end

    task check(input string name, input logic [31:0] seen, exp);
        begin
            tests_run++;
            if (seen !== exp) begin
                fails++;
                $display("MISMATCH %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask

    task stop_test();
        begin
            $display("checks %0d mismatches %0d", tests_run, fails);
            if (fails == 0 && tests_run > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    // --------------------------------
    // One command: note expectation, send, wait
    // --------------------------------
    task issue(input logic [63:0] lun, input logic [31:0] cntl,
               input logic [7:0] opc, b1, pg, input logic [31:0] dl,
               input logic ok);
        fech_exp_t   e;
        logic [31:0] nat, n;
        logic [3:0]  key;
        logic [7:0]  asc;
        int          i;
        begin
            nat = (opc == `FECH_OP_INQUIRY) ? 32'd36 :
                  (opc == `FECH_OP_RPT_LUN) ? 32'd16 :
                  (opc == `FECH_OP_REQ_SNS) ? 32'd18 : 32'd0;
            {key, asc} = {`FECH_KEY_NONE, `FECH_ASC_NONE};
            if (lun != 64'h0)
                {key, asc} = {`FECH_KEY_ILLEGAL, `FECH_ASC_BAD_LUN};
            else if (cntl != 32'h1 && cntl != 32'h2)
                {key, asc} = {`FECH_KEY_ILLEGAL, `FECH_ASC_BAD_FLD};
            else if (nat == 0 && opc != `FECH_OP_TUR)
                {key, asc} = {`FECH_KEY_ILLEGAL, `FECH_ASC_BAD_OP};
            else if (opc == `FECH_OP_INQUIRY && b1[1:0] == 0 && pg != 0)
                {key, asc} = {`FECH_KEY_ILLEGAL, `FECH_ASC_BAD_FLD};
            else if (opc == `FECH_OP_TUR && !ok)
                {key, asc} = {`FECH_KEY_NRDY, `FECH_ASC_NRDY};
            e = '{default: 32'h0};
            if (key != 4'h0) begin
                e.s10 = 32'h02;
                e.s11 = {24'h0, `FECH_ST_CHECK};
                e.sl = 32'd18;
                e.nr = 32'd42;
                e.key = {28'h0, key};
                e.asc = {24'h0, asc};
            end else begin
                // Writes move no data at all
                if (cntl == 32'h1) nat = 32'h0;
                n = (nat < dl) ? nat : dl;
                e.nr = 32'd24;
                e.nd = n;
                e.nx = {31'h0, n != 0};
                e.xl = n;
                e.res = (nat < dl) ? dl - nat : nat - dl;
                e.s10 = (nat < dl) ? 32'h08 : (nat > dl) ? 32'h04 : 32'h0;
                if (n != 0 && opc == `FECH_OP_INQUIRY)
                    e.d0 = {24'h0, `FECH_PDT_ENCL};
                if (n != 0 && opc == `FECH_OP_REQ_SNS)
                    e.d0 = 32'h70;
            end
            q.push_back(e);
            unit_ready = ok;
            fech_initiator_model_inst.send_cmd({lun, cntl, opc, b1, pg,
                                                104'h0, dl});
            i = 0;
            while (q.size() != 0 && i < 1000) begin
                @(posedge clock);
                i++;
            end
            #1;
            tnum++;
            $display("test %0d done", tnum);
        end
    endtask

    // --------------------------------
    // Response monitor
    // --------------------------------
    always @(negedge clock) begin : monitor
        fech_exp_t  e;
        logic [7:0] b [0:63];
        logic [7:0] rs;
        int         k;
        if (fech_initiator_model_inst.done) begin
            b = fech_initiator_model_inst.rsp_buf;
            rs = 8'h00;
            if (q.size() == 0) begin
                fails++;
                $display("MISMATCH response expected 0 seen 1");
            end else begin
                e = q.pop_front();
                for (k = 0; k < 24; k++)
                    if (k < 10 || k > 19) rs = rs | b[k];
                check("reserved", {24'h0, rs}, 32'h0);
                check("status2", {24'h0, b[10]},
                      e.s10);
                check("status3", {24'h0, b[11]}, e.s11);
                check("resid", {b[12], b[13], b[14], b[15]},
                      e.res);
                check("snslen", {b[16], b[17], b[18], b[19]},
                      e.sl);
                check("rsp_len", fech_initiator_model_inst.nr,
                      e.nr);
                check("data_len", fech_initiator_model_inst.nd,
                      e.nd);
                check("xrdy_cnt", fech_initiator_model_inst.nx,
                      e.nx);
                check("xrdy_len", fech_initiator_model_inst.xl,
                      e.xl);
                check("data0", {24'h0, fech_initiator_model_inst.d0},
                      e.d0);
                if (e.s11 == 32'h2) begin
                    check("key", {28'h0, b[26][3:0]}, e.key);
                    check("asc", {24'h0, b[36]}, e.asc);
                end
            end
        end
    end

    initial begin
        seed = 32'hd01318ec;
        ops = '{`FECH_OP_INQUIRY, `FECH_OP_RPT_LUN, `FECH_OP_REQ_SNS,
                `FECH_OP_TUR};
        {clock, rst, unit_ready, slow, stall} = {3'b011, 1'b0, 3'b000};
        {fails, tests_run, cyc, tnum} = {32'h0, 32'h0, 32'h0, 32'h0};
        cmd_data = 8'h00;
        repeat (16) @(posedge clock);
        #1;
        rst = 1'b0;
        issue(64'h0, 32'h2, ops[0], 8'h0, 8'h0, 32'd36, 1'b1);
        issue(64'h0, 32'h2, ops[0], 8'h1, 8'h0, 32'd36, 1'b1);
        issue(64'h0, 32'h2, ops[0], 8'h0, 8'h0, 32'd100, 1'b1);
        issue(64'h0, 32'h2, ops[0], 8'h0, 8'h0, 32'd10, 1'b1);
        issue(64'h0, 32'h2, ops[0], 8'h0, 8'h0, 32'd0, 1'b1);
        issue(64'h0, 32'h2, ops[1], 8'h0, 8'h0, 32'd16, 1'b1);
        issue(64'h0, 32'h2, ops[2], 8'h0, 8'h0, 32'd18, 1'b1);
        issue(64'h0, 32'h2, ops[3], 8'h0, 8'h0, 32'd0, 1'b1);
        slow = 1'b1;
        issue(64'h0, 32'h2, ops[3], 8'h0, 8'h0, 32'd0, 1'b0);
        issue(64'h0, 32'h2, ops[2], 8'h0, 8'h0, 32'd18, 1'b1);
        issue(64'h0, 32'h2, ops[0], 8'h0, 8'h1, 32'd36, 1'b1);
        issue(64'h0010_0000_0000_0000, 32'h2, ops[0], 8'h0, 8'h0,
              32'd36, 1'b1);
        issue(64'h0, 32'h3, ops[0], 8'h0, 8'h0, 32'd36, 1'b1);
        issue(64'h0, 32'h0, ops[1], 8'h0, 8'h0, 32'd16, 1'b1);
        issue(64'h0, 32'h1, ops[0], 8'h0, 8'h0, 32'd8, 1'b1);
        issue(64'h0, 32'h2, 8'h1c, 8'h0, 8'h0, 32'd8, 1'b1);
        for (t = 0; t < 10; t++) begin
            r = $random(seed);
            op = ops[r[1:0]];
            slow = r[11];
            issue(64'h0, 32'h2, op, 8'h0, 8'h0, {26'h0, r[9:4]},
                  r[10]);
        end
        check("order", 32'(fech_initiator_model_inst.order_err),
              32'h0);
        stop_test();
    end
endmodule // fech_cmd_handler_tb

/* tb/fech_initiator_model.sv */
// Initiator model facing the enclosure command handler
`timescale 1ns/100ps

module fech_initiator_model
    import fech_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    output logic             cmd_valid,
    input  wire logic        cmd_ready,
    output logic [7:0]       cmd_data,
    input  wire logic        xrdy_valid,
    output logic             xrdy_ready,
    input  wire logic [31:0] xrdy_len,
    input  wire logic        dout_valid,
    output logic             dout_ready,
    input  wire logic [7:0]  dout_data,
    input  wire logic        dout_last,
    input  wire logic        rsp_valid,
    output logic             rsp_ready,
    input  wire logic [7:0]  rsp_data,
    input  wire logic        rsp_last,
    input  wire logic        slow,
    input  wire logic [2:0]  stall
);
    logic [7:0]  rsp_buf [0:63];
    logic [31:0] nr, nd, nx, xl;
    logic [7:0]  d0;
    logic        done;
    int          order_err;

    initial begin
        cmd_valid = 1'b0;
        cmd_data = 8'h00;
        order_err = 0;
        done = 1'b0;
    end

    // Slow mode stalls each ready line on its own random bit
    assign xrdy_ready = !(slow && stall[0]);
    assign dout_ready = !(slow && stall[1]);
    assign rsp_ready = !(slow && stall[2]);

    // --------------------------------
    // Command unit, sent whole
    // --------------------------------
    task send_cmd(input logic [255:0] unit);
        int i;
        begin
            nr = 0;
            nd = 0;
            nx = 0;
            xl = 0;
            d0 = 8'h00;
            for (i = 0; i < 32; i++) begin
                cmd_valid = 1'b1;
                cmd_data = unit[255-8*i -: 8];
                @(posedge clock);
                while (!cmd_ready) @(posedge clock);
                #1;
            end
            cmd_valid = 1'b0;
            // Released bus must not keep looking valid
            cmd_data = ~cmd_data;
        end
    endtask

    // --------------------------------
    // Collect transfer-ready, data, response
    // --------------------------------
    always @(posedge clock) begin
        done <= 1'b0;
        if (!rst) begin
            if (xrdy_valid && xrdy_ready) begin
                nx <= nx + 1;
                xl <= xrdy_len;
            end
            if (dout_valid && dout_ready) begin
                if (nd == 0) d0 <= dout_data;
                if (nx == 0) order_err++;
                if (dout_last != (nd + 1 == xrdy_len)) order_err++;
                nd <= nd + 1;
            end
            if (rsp_valid && rsp_ready) begin
                rsp_buf[nr[5:0]] <= rsp_data;
                nr <= nr + 1;
                done <= rsp_last;
            end
        end
    end
endmodule // fech_initiator_model
